// ### evp_arbiter.sv
// Combinational picker: most urgent requester, lowest number on ties.
// Assumes eff_i packs four bits per entry, entry 0 lowest.
`timescale 1ns/1ps
`include "evp_regs.svh"
module evp_arbiter
	import evp_pkg::*;
#(
	parameter int N = 60
)
(
	input  wire logic [N-1:0]   req_i,
	input  wire logic [4*N-1:0] eff_i,
	output logic                any_o,
	output evp_vec_t            num_o,
	output evp_eff_t            eff_o
);

	// Vector numbers are six bits wide
	if (N < 1 || N > 64)
		$error("evp_arbiter: N out of range");

	// ======================================================
	// Scan from the top with <= so the lowest number wins a tie
	always_comb
	begin
		any_o = 1'b0;
		num_o = '0;
		eff_o = `EVP_EFF_IDLE;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req_i[i] && eff_i[4*i +: 4] <= eff_o)
			begin
				any_o = 1'b1;
				num_o = evp_vec_t'(i);
				eff_o = eff_i[4*i +: 4];
			end
		end
	end

endmodule

// ### evp_core.sv
// Exception vector lookup, table base and priority resolution.
// Assumes irq_i and sys_req_i come from logic on clock_i, nmi_pin_i
// from a pin, and that the core pulses take_ack_i and ret_i.
`timescale 1ns/1ps
`include "evp_regs.svh"
module evp_core
	import evp_pkg::*;
#(
	parameter int          IRQ_LINES = `EVP_IRQ_LINES,
	parameter logic [63:0] IMPL_MASK = `EVP_IMPL_MASK
)
(
	input  wire logic                 clock_i,
	input  wire logic                 rst_n_i,
	input  wire logic [IRQ_LINES-1:0] irq_i,
	input  wire logic [15:0]          sys_req_i,
	input  wire logic                 nmi_pin_i,
	input  wire logic                 prio_wr_i,
	input  wire evp_vec_t             prio_wr_num_i,
	input  wire evp_prio_t            prio_wr_val_i,
	input  wire logic                 base_wr_i,
	input  wire logic                 base_priv_i,
	input  wire evp_addr_t            base_wr_data_i,
	input  wire logic                 take_ack_i,
	input  wire logic                 ret_i,
	input  wire evp_vec_t             ret_num_i,
	output logic                      take_req_o,
	output evp_vec_t                  take_num_o,
	output evp_addr_t                 fetch_addr_o,
	output logic                      preempt_o,
	output evp_addr_t                 sp_addr_o,
	output logic                      base_refused_o,
	output logic                      active_any_o
);

	localparam int N = IRQ_LINES + `EVP_NUM_SYS;

	// Full-width copies so each use slices only the vectors it has
	localparam logic [63:0] CFG_ALL  = `EVP_CFG_MASK;
	localparam logic [63:0] PEND_ALL = `EVP_PEND_RST;

	// Six-bit vector numbers cap the line count
	if (IRQ_LINES < 1 || N > 64)
		$error("evp_core: IRQ_LINES out of range");

	// ======================================================
	// Declarations
	logic [N-1:0]   pend_reg;
	logic [N-1:0]   act_reg;
	logic [N-1:0]   pend_next;
	logic [N-1:0]   act_next;
	logic [N-1:0]   set_vec;
	logic [N-1:0]   src_vec;
	logic [N-1:0]   impl_vec;
	logic [N-1:0]   cfg_vec;
	logic [4*N-1:0] eff_all;
	evp_prio_t      prio_reg [N];
	evp_addr_t      base_reg;
	evp_addr_t      base_next;
	evp_offer_e     state_reg;
	evp_offer_e     state_next;
	evp_vec_t       num_reg;
	evp_addr_t      addr_reg;
	logic           preempt_reg;
	logic           refused_reg;
	logic           nmi_level;
	logic           nmi_prev_reg;
	logic           nmi_rise;
	logic           pend_any;
	evp_vec_t       win_num;
	evp_eff_t       win_eff;
	logic           act_any;
	evp_eff_t       act_eff;
	evp_eff_t       run_eff;
	logic           want;
	logic           ack_fire;
	logic           base_in_range;
	logic           base_ok;

	// ======================================================
	// NMI pin path and request sources
	evp_sync3 u_nmi_sync (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.pin_i   (nmi_pin_i),
		.level_o (nmi_level)
	);

	// Reset vector is only ever pended by reset itself
	assign nmi_rise = nmi_level & ~nmi_prev_reg;
	assign src_vec  = {irq_i, sys_req_i[15:3], nmi_rise, 2'b00};
	assign impl_vec = IMPL_MASK[N-1:0];
	assign cfg_vec  = CFG_ALL[N-1:0];
	assign set_vec  = src_vec & impl_vec;
	assign ack_fire = take_ack_i & take_req_o;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			nmi_prev_reg <= 1'b0;
		else
			nmi_prev_reg <= nmi_level;
	end

	// ======================================================
	// Per-vector state: pending, active, priority, urgency
	for (genvar i = 0; i < N; i++)
	begin : g_vec
		logic clr_pend;
		logic set_act;
		logic clr_act;
		logic wr_hit;

		assign clr_pend = ack_fire && take_num_o == evp_vec_t'(i);
		assign set_act  = clr_pend && i != `EVP_VEC_RESET;
		assign clr_act  = ret_i && ret_num_i == evp_vec_t'(i);
		assign wr_hit   = prio_wr_i && prio_wr_num_i == evp_vec_t'(i)
			&& cfg_vec[i];

		// New arrival wins over the clear of a take
		assign pend_next[i] = set_vec[i] | (pend_reg[i] & ~clr_pend);
		assign act_next[i]  = set_act | (act_reg[i] & ~clr_act);

		// Fixed levels sit below every configurable one
		if (i == `EVP_VEC_RESET)
		begin : g_rst
			assign eff_all[4*i +: 4] = `EVP_EFF_RESET;
		end
		else if (i == `EVP_VEC_NMI)
		begin : g_nmi
			assign eff_all[4*i +: 4] = `EVP_EFF_NMI;
		end
		else if (i == `EVP_VEC_HARD)
		begin : g_hard
			assign eff_all[4*i +: 4] = `EVP_EFF_HARD;
		end
		else
		begin : g_cfg
			assign eff_all[4*i +: 4] = {1'b0, prio_reg[i]}
				+ `EVP_EFF_OFFS;
		end

		always_ff @(posedge clock_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
			begin
				pend_reg[i] <= PEND_ALL[i];
				act_reg[i]  <= 1'b0;
				prio_reg[i] <= `EVP_PRIO_RST;
			end
			else
			begin
				pend_reg[i] <= pend_next[i];
				act_reg[i]  <= act_next[i];
				if (wr_hit)
					prio_reg[i] <= prio_wr_val_i;
			end
		end
	end

	// ======================================================
	// Pending winner and running level
	evp_arbiter #(.N(N)) u_pend_arb (
		.req_i (pend_reg),
		.eff_i (eff_all),
		.any_o (pend_any),
		.num_o (win_num),
		.eff_o (win_eff)
	);

	// Most urgent active handler is the one running
	evp_arbiter #(.N(N)) u_act_arb (
		.req_i (act_reg),
		.eff_i (eff_all),
		.any_o (act_any),
		.num_o (),
		.eff_o (act_eff)
	);

	// Strict compare: an equal level waits pending
	assign run_eff = act_any ? act_eff : `EVP_EFF_IDLE;
	assign want    = pend_any && win_eff < run_eff;

	// ======================================================
	// Offer sequencer; SETTLE lets the take reach the state bits
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			EVP_IDLE:
				if (want)
					state_next = EVP_OFFER;
			EVP_OFFER:
				if (ack_fire)
					state_next = EVP_SETTLE;
				else if (!want)
					state_next = EVP_IDLE;
			EVP_SETTLE:
				state_next = EVP_IDLE;
			default:
				state_next = EVP_IDLE;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_reg   <= EVP_IDLE;
			num_reg     <= '0;
			addr_reg    <= `EVP_BASE_RST;
			preempt_reg <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			preempt_reg <= want & act_any;
			if (want)
			begin
				num_reg  <= win_num;
				addr_reg <= base_reg
					+ ({26'h0, win_num} << `EVP_SLOT_SHIFT);
			end
		end
	end

	// ======================================================
	// Table base relocation; low byte dropped, not checked
	assign base_next     = {base_wr_data_i[31:`EVP_BASE_LOW_BITS],
		8'h00};
	assign base_in_range = base_next >= `EVP_BASE_MIN
		&& base_next <= `EVP_BASE_MAX;
	assign base_ok       = base_wr_i & base_priv_i & base_in_range;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			base_reg    <= `EVP_BASE_RST;
			refused_reg <= 1'b0;
		end
		else
		begin
			refused_reg <= base_wr_i & ~base_ok;
			if (base_ok)
				base_reg <= base_next;
		end
	end

	// ======================================================
	// Outputs
	assign take_req_o     = state_reg == EVP_OFFER;
	assign take_num_o     = num_reg;
	assign fetch_addr_o   = addr_reg;
	assign preempt_o      = preempt_reg;
	assign sp_addr_o      = base_reg;
	assign base_refused_o = refused_reg;
	assign active_any_o   = act_any;

	// ======================================================
	// Checks
	logic base_wr_seen_reg;
	logic prio_wr_seen_reg;
	logic tie_ok;

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			base_wr_seen_reg <= 1'b0;
			prio_wr_seen_reg <= 1'b0;
		end
		else
		begin
			base_wr_seen_reg <= base_wr_seen_reg | base_ok;
			prio_wr_seen_reg <= prio_wr_seen_reg | prio_wr_i;
		end
	end

	// No lower-numbered pending vector is as urgent as the winner
	always_comb
	begin
		tie_ok = 1'b1;
		for (int j = 0; j < N; j++)
			if (pend_reg[j] && evp_vec_t'(j) < win_num
				&& eff_all[4*j +: 4] <= win_eff)
				tie_ok = 1'b0;
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	fetch_addr_a: assert property (take_req_o && $stable(base_reg) |->
		fetch_addr_o == base_reg + ({26'h0, take_num_o} << 2))
		else $error("fetch address not base plus four times number");
	irq_slot_a: assert property (take_req_o && take_num_o == 6'd16
		&& base_reg == 32'h0 && $stable(base_reg) |->
		fetch_addr_o == 32'h0000_0040)
		else $error("first interrupt slot not at 0x40");
	base_reset_a: assert property (!base_wr_seen_reg |->
		base_reg == 32'h0 && sp_addr_o == 32'h0)
		else $error("table base moved without accepted write");
	base_range_a: assert property (base_wr_seen_reg |->
		base_reg >= 32'h100 && base_reg <= 32'h3FFF_FF00
		&& base_reg[7:0] == 8'h00)
		else $error("table base outside allowed range");
	base_priv_a: assert property (base_wr_i && !base_priv_i |=>
		$stable(base_reg) && base_refused_o)
		else $error("unprivileged base write took effect");
	prio_reset_a: assert property (!prio_wr_seen_reg |->
		eff_all[4*4 +: 4] == 4'h3 && eff_all[4*16 +: 4] == 4'h3)
		else $error("configurable priority not zero after reset");
	nmi_rank_a: assert property (pend_reg[2] && !pend_reg[1] |->
		win_num == 6'd2)
		else $error("pending NMI not most urgent");
	tie_order_a: assert property (pend_any |-> tie_ok)
		else $error("tie not resolved to smallest number");
	preempt_a: assert property (state_reg == EVP_IDLE && pend_any
		&& win_eff < run_eff |=> take_req_o)
		else $error("more urgent exception not offered");
	no_equal_a: assert property (pend_any && act_any
		&& win_eff >= act_eff && state_reg != EVP_OFFER |=> !take_req_o)
		else $error("equal priority preempted a handler");
	keep_pend_a: assert property (|set_vec |=>
		(pend_reg & $past(set_vec)) == $past(set_vec))
		else $error("arrival not recorded as pending");
	take_a: assert property (ack_fire && take_num_o > 6'd1 |=>
		act_reg[$past(take_num_o)] ##1 !take_req_o)
		else $error("taken exception not made active");

	nest_c: cover property (ack_fire && act_any);
	nmi_c: cover property (ack_fire && take_num_o == 6'd2);
	reloc_c: cover property (base_ok ##[1:20] ack_fire);
	tie_c: cover property (pend_any && act_any && win_eff == act_eff);

endmodule

// ### evp_core_ack_model.sv
// Stand-in for the processor core: accepts each offer after a delay.
// Assumes block outputs settle within 1 ns of the clock edge.
`timescale 1ns/1ps
module evp_core_ack_model
(
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       take_req_i,
	input  wire logic [3:0] delay_i,
	output logic            take_ack_o
);
	int wait_cnt = 0;

	// ==================================================
	// Acknowledge
	// One-cycle ack, never without an offer up; a delay shows
	// that the offer stands while the core is slow
	always @(posedge clock_i)
	begin
		#1;
		if (!rst_n_i || take_req_i !== 1'b1 || take_ack_o)
		begin
			take_ack_o = 1'b0;
			wait_cnt = 0;
		end
		else if (wait_cnt >= int'(delay_i))
			take_ack_o = 1'b1;
		else
			wait_cnt++;
	end
endmodule

// ### evp_core_tb_top.sv
// Self-checking bench of the exception vector and priority block.
// Assumes the ack model plays the core; the bench plays the sources.
`timescale 1ns/1ps
module evp_core_tb_top
	import evp_pkg::*;
;
	// ==================================================
	// Signals
	logic        clock_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [43:0] irq_i;
	logic [15:0] sys_req_i;
	logic        nmi_pin_i, prio_wr_i, base_wr_i, base_priv_i, ret_i;
	evp_vec_t    prio_wr_num_i, ret_num_i, take_num_o;
	evp_prio_t   prio_wr_val_i;
	evp_addr_t   base_wr_data_i, fetch_addr_o, sp_addr_o, base;
	logic        take_ack_i, take_req_o, preempt_o;
	logic        base_refused_o, active_any_o;
	logic [3:0]  ack_delay = 4'h0;
	int          n_fail = 0;
	int          num_checks = 0;

	always #20 clock_i = ~clock_i;

	evp_core u_dut
	(
		.clock_i, .rst_n_i, .irq_i, .sys_req_i, .nmi_pin_i,
		.prio_wr_i, .prio_wr_num_i, .prio_wr_val_i, .base_wr_i,
		.base_priv_i, .base_wr_data_i, .take_ack_i, .ret_i,
		.ret_num_i, .take_req_o, .take_num_o, .fetch_addr_o,
		.preempt_o, .sp_addr_o, .base_refused_o, .active_any_o
	);

	evp_core_ack_model u_core
	(
		.clock_i, .rst_n_i, .take_req_i (take_req_o),
		.delay_i (ack_delay), .take_ack_o (take_ack_i)
	);

	// ==================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Inputs always move 1 ns after the edge
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic final_report;
		$display("checks=%0d mismatches=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Bounded wait on the offer level; a hang ends the run
	task automatic wait_lvl(input logic want);
		int i;
		i = 0;
		while (take_req_o !== want && i < 40)
		begin
			step(1);
			i++;
		end
		if (i == 40)
		begin
			chk({31'h0, take_req_o}, {31'h0, want});
			final_report();
		end
	endtask

	// Handler words as software lays them out; bit 0 marks compact code
	function automatic evp_addr_t hnd(input evp_addr_t slot);
		return {16'h0000, 8'h10, slot[5:0], 2'b01};
	endfunction

	// Offer must carry number, fetch address and preempt flag
	task automatic take_chk(input evp_vec_t n, input logic pre);
		wait_lvl(1'b1);
		chk({26'h0, take_num_o}, {26'h0, n});
		chk(fetch_addr_o, base + {24'h0, n, 2'b00});
		chk(hnd((fetch_addr_o - base) >> 2), hnd({26'h0, n}));
		chk({31'h0, preempt_o}, {31'h0, pre});
		wait_lvl(1'b0);
	endtask

	// Something pends yet nothing may be offered
	task automatic quiet;
		step(6);
		chk({31'h0, take_req_o}, 32'h0);
		chk({31'h0, active_any_o}, 32'h1);
	endtask

	task automatic pulse(input logic [43:0] irq, input logic [15:0] sys);
		irq_i = irq;
		sys_req_i = sys;
		step(1);
		irq_i = 44'h0;
		sys_req_i = 16'h0;
		step(1);
	endtask

	task automatic pri(input evp_vec_t n, input evp_prio_t v);
		prio_wr_i = 1'b1;
		prio_wr_num_i = n;
		prio_wr_val_i = v;
		step(1);
		prio_wr_i = 1'b0;
		step(1);
	endtask

	task automatic rt(input evp_vec_t n);
		ret_i = 1'b1;
		ret_num_i = n;
		step(1);
		ret_i = 1'b0;
		step(1);
	endtask

	task automatic bw(input evp_addr_t d, input logic priv, input logic ok);
		base_wr_i = 1'b1;
		base_priv_i = priv;
		base_wr_data_i = d;
		step(1);
		base_wr_i = 1'b0;
		if (ok)
			base = d;
		chk(sp_addr_o, base);
		chk({31'h0, base_refused_o}, {31'h0, ~ok});
		step(1);
		chk({31'h0, base_refused_o}, 32'h0);
	endtask

	// ==================================================
	// Scenarios
	// Reset: vector 1 first from base zero, priorities back to zero
	task automatic t_reset;
		rst_n_i = 1'b0;
		base = 32'h0;
		step(10);
		rst_n_i = 1'b1;
		take_chk(6'd1, 1'b0);
		chk(sp_addr_o, 32'h0);
		chk({31'h0, active_any_o}, 32'h0);
		pulse(44'h3, 16'h0);
		take_chk(6'd16, 1'b0);
		quiet();
		rt(6'd16);
		take_chk(6'd17, 1'b0);
		rt(6'd17);
		$display("test reset done");
	endtask

	task automatic t_base;
		bw(32'h2000_0100, 1'b0, 1'b0);
		bw(32'h0000_0000, 1'b1, 1'b0);
		bw(32'h4000_0000, 1'b1, 1'b0);
		bw(32'h0000_0100, 1'b1, 1'b1);
		bw(32'h3FFF_FF00, 1'b1, 1'b1);
		bw(32'h2000_0100, 1'b1, 1'b1);
		$display("test base done");
	endtask

	// Equal levels: lower number waits behind a higher one
	task automatic t_tie;
		pulse(44'h2, 16'h0);
		take_chk(6'd17, 1'b0);
		pulse(44'h1, 16'h0);
		quiet();
		rt(6'd17);
		take_chk(6'd16, 1'b0);
		rt(6'd16);
		pulse(44'h3, 16'h10);
		take_chk(6'd4, 1'b0);
		quiet();
		rt(6'd4);
		take_chk(6'd16, 1'b0);
		rt(6'd16);
		take_chk(6'd17, 1'b0);
		rt(6'd17);
		chk({31'h0, active_any_o}, 32'h0);
		$display("test tie done");
	endtask

	// Slow core; smaller value wins and strictly preempts
	task automatic t_prio;
		ack_delay = 4'h3;
		pri(6'd16, 3'd5);
		pri(6'd17, 3'd2);
		pri(6'd58, 3'd7);
		pulse(44'h3, 16'h0);
		take_chk(6'd17, 1'b0);
		quiet();
		rt(6'd17);
		take_chk(6'd16, 1'b0);
		pulse(44'h400_0000_0000, 16'h0);
		quiet();
		pulse(44'h2, 16'h0);
		take_chk(6'd17, 1'b1);
		rt(6'd17);
		quiet();
		rt(6'd16);
		take_chk(6'd58, 1'b0);
		rt(6'd58);
		ack_delay = 4'h0;
		$display("test prio done");
	endtask

	// Fixed levels outrank level zero and each other
	task automatic t_fixed;
		pri(6'd16, 3'd0);
		pri(6'd2, 3'd7);
		pulse(44'h1, 16'h0);
		take_chk(6'd16, 1'b0);
		pulse(44'h0, 16'h8);
		take_chk(6'd3, 1'b1);
		nmi_pin_i = 1'b1;
		take_chk(6'd2, 1'b1);
		nmi_pin_i = 1'b0;
		rt(6'd2);
		rt(6'd3);
		rt(6'd16);
		chk({31'h0, active_any_o}, 32'h0);
		$display("test fixed done");
	endtask

	// ==================================================
	// Main sequence
	initial
	begin
		{irq_i, sys_req_i, nmi_pin_i, prio_wr_i, prio_wr_num_i,
			prio_wr_val_i, base_wr_i, base_priv_i, base_wr_data_i,
			ret_i, ret_num_i} = '0;
		t_reset();
		t_base();
		t_tie();
		t_prio();
		t_fixed();
		t_reset();
		final_report();
	end
endmodule

// ### evp_pkg.sv
// Types shared by the exception vector and priority block.
// Assumes nothing of its surroundings.
package evp_pkg;

	// ======================================================
	// Field types
	typedef logic [5:0]  evp_vec_t;
	typedef logic [2:0]  evp_prio_t;
	typedef logic [3:0]  evp_eff_t;
	typedef logic [31:0] evp_addr_t;

	// ======================================================
	// Offer sequencer towards the core
	typedef enum logic [1:0] {
		EVP_IDLE,
		EVP_OFFER,
		EVP_SETTLE
	} evp_offer_e;

endpackage

// ### evp_regs.svh
// Constants of the exception vector and priority block: slot layout,
// table base limits, reset values and the fixed urgency levels.
// Assumes the including file keeps one copy only through the guard.
`ifndef EVP_REGS_SVH
`define EVP_REGS_SVH

// ==========================================================
// Vector table layout
`define EVP_NUM_SYS        16
`define EVP_IRQ_LINES      44
`define EVP_SLOT_SHIFT     2
`define EVP_VEC_RESET      1
`define EVP_VEC_NMI        2
`define EVP_VEC_HARD       3
// Vectors that exist: system set 1-6, 11, 12, 14, 15 plus used lines
`define EVP_IMPL_MASK      64'h0400_F7FC_00BF_D87E
// Same set less reset, NMI and hard fault
`define EVP_CFG_MASK       64'h0400_F7FC_00BF_D870
`define EVP_PEND_RST       64'h0000_0000_0000_0002

// ==========================================================
// Table base relocation
`define EVP_BASE_RST       32'h0000_0000
`define EVP_BASE_MIN       32'h0000_0100
`define EVP_BASE_MAX       32'h3FFF_FF00
`define EVP_BASE_LOW_BITS  8

// ==========================================================
// Urgency: smaller is more urgent, configurable shifted past fixed
`define EVP_PRIO_RST       3'h0
`define EVP_EFF_RESET      4'h0
`define EVP_EFF_NMI        4'h1
`define EVP_EFF_HARD       4'h2
`define EVP_EFF_OFFS       4'h3
`define EVP_EFF_IDLE       4'hF

`endif

// ### evp_sync3.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes pin_i is asynchronous to clock_i.
`timescale 1ns/1ps
module evp_sync3
	import evp_pkg::*;
(
	input  wire logic clock_i,
	input  wire logic rst_n_i,
	input  wire logic pin_i,
	output logic      level_o
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// ======================================================
	// Chain; the output moves only when stages two and three agree
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s1_reg  <= 1'b0;
			s2_reg  <= 1'b0;
			s3_reg  <= 1'b0;
			level_o <= 1'b0;
		end
		else
		begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level_o <= s3_reg;
		end
	end

endmodule
